/* design/esa_pkg.sv */
/*
   Constants, carrier types and shared decode functions for the admission
   checks of the privileged enclave system instruction.
   Assumes one core clock domain; all inputs arrive from logic on that clock.
*/
`default_nettype none
package esa_pkg;

   // Opcode bytes of the privileged enclave system instruction
   localparam logic [7:0] OPC_BYTE0 = 8'h0F;
   localparam logic [7:0] OPC_BYTE1 = 8'h01;
   localparam logic [7:0] OPC_BYTE2 = 8'hCF;

   localparam int ACC_W    = 64;
   localparam int LEAF_W   = 32;
   localparam int BITMAP_W = 64;
   localparam int BMIDX_W  = 6;
   localparam int CTRL_W   = 16;
   localparam int SLOTS    = 4;

   // Leaf space; the leaf codes are implementation choices
   localparam logic [LEAF_W-1:0]  LEAF_COUNT     = 32'h00000018;
   localparam logic [LEAF_W-1:0]  TRACK_LEAF     = 32'h0000000C;
   localparam logic [LEAF_W-1:0]  TRACK_CHK_LEAF = 32'h00000011;
   localparam logic [LEAF_W-1:0]  LAST_DIRECT    = 32'h0000003E;
   localparam logic [BMIDX_W-1:0] CATCHALL_BIT   = 6'h3F;

   localparam logic [1:0]        TOP_CPL       = 2'h0;
   localparam logic [LEAF_W-1:0] FAULT_ERRCODE = 32'h00000000;

   typedef struct packed {
      logic busLock;
      logic opSize;
      logic repeatPfx;
      logic vecExt;
      logic segOverride;
      logic addrSize;
      logic regExt;
   } esa_prefix_t;

   typedef struct packed {
      logic       protEnable;
      logic       v86;
      logic       smm;
      logic [1:0] cpl;
      logic       gen1Feature;
      logic       featLock;
      logic       enclaveEnable;
      logic       pagingEnable;
      logic       longActive;
      logic       csLong;
      logic       dsExpandDown;
      logic       guestMode;
      logic       exitCtl;
      logic       txnActive;
   } esa_cpu_t;

   typedef enum logic [2:0] {
      ESA_NONE,
      ESA_ADMIT,
      ESA_TXN_ABORT,
      ESA_UD,
      ESA_VMEXIT,
      ESA_GP,
      ESA_CONFLICT
   } esa_outcome_t;

   typedef struct packed {
      esa_outcome_t      outcome;
      logic [LEAF_W-1:0] errCode;
      logic [LEAF_W-1:0] leaf;
      logic              wide64;
      logic              pageConflict;
      logic              trackQual;
   } esa_result_t;

   function automatic logic esa_leaf_valid(input logic [LEAF_W-1:0] leaf);
      esa_leaf_valid = leaf < LEAF_COUNT;
   endfunction

   function automatic logic esa_is_track(input logic [LEAF_W-1:0] leaf);
      esa_is_track = (leaf == TRACK_LEAF) || (leaf == TRACK_CHK_LEAF);
   endfunction

   function automatic logic [BMIDX_W-1:0] esa_bm_index(input logic [LEAF_W-1:0] leaf);
      esa_bm_index = (leaf > LAST_DIRECT) ? CATCHALL_BIT : leaf[BMIDX_W-1:0];
   endfunction

endpackage
`default_nettype wire

/* design/esa_track_lock.sv */
/*
   Busy table for control structures held by the epoch-tracking leaves.
   Assumes acquire and release come from logic on the same clock; a release
   names the structure whose tracking leaf has finished.
*/
`timescale 1ns/1ps
`default_nettype none
module esa_track_lock
   import esa_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              acquire,
   input  wire logic [CTRL_W-1:0] acquireId,
   input  wire logic              retire,
   input  wire logic [CTRL_W-1:0] releaseId,
   output logic                   granted,
   output logic                   busyAny
);

   logic              slotValid [SLOTS];
   logic [CTRL_W-1:0] slotId    [SLOTS];
   logic              hit;
   logic              freeFound;
   logic [1:0]        freeIdx;

   // A full table also refuses; the caller sees it as a conflict
   always_comb
   begin
      hit       = 1'b0;
      freeFound = 1'b0;
      freeIdx   = 2'h0;
      busyAny   = 1'b0;
      for (int i = 0; i < SLOTS; i++)
      begin
         busyAny = busyAny | slotValid[i];
         if (slotValid[i] && slotId[i] == acquireId)
            hit = 1'b1;
         if (!slotValid[i] && !freeFound)
         begin
            freeFound = 1'b1;
            freeIdx   = 2'(i);
         end
      end
      granted = acquire && !hit && freeFound;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < SLOTS; i++)
         begin
            slotValid[i] <= 1'b0;
            slotId[i]    <= '0;
         end
      end
      else
      begin
         for (int i = 0; i < SLOTS; i++)
         begin
            if (retire && slotValid[i] && slotId[i] == releaseId)
               slotValid[i] <= 1'b0;
         end
         if (granted)
         begin
            slotValid[freeIdx] <= 1'b1;
            slotId[freeIdx]    <= acquireId;
         end
      end
   end

endmodule
`default_nettype wire

/* design/esa_admission.sv */
/*
   Admission and fault checks for the privileged enclave system instruction:
   leaf select, mode, privilege, prefix, feature-control and paging checks,
   the per-leaf hypervisor exit bitmap and tracking-leaf exclusion.
   Assumes decode, state and bitmap inputs come from logic on the same clock
   and hold steady in the cycle where reqValid is high.
*/
// Summary of operation
// - Recognise 0F 01 CF as this instruction
// - Leaf from low 32 accumulator bits only
// - Invalid opcode: no protection, v86, SMM
// - Invalid opcode when privilege level above zero
// - Invalid opcode when gen1 feature bit clear
// - Invalid opcode on lock/66/repeat/vector prefixes
// - Guest exit from bitmap; leaves above 62 use 63
// - Exit check after opcode checks, before GP
// - GP(0) when feature lock or enable clear
// - GP(0) on undefined or unsupported leaf
// - GP(0) when paging is disabled
// - GP(0) for expand-down data outside 64-bit
// - Width 64 only in 64-bit mode
// - Ignore segment, address-size and extension prefixes
// - Active transaction aborts before any other check
// - Tracking leaves exclusive per control structure; conflict reports page error
// - Compatibility mode uses protected-mode checks
`timescale 1ns/1ps
`default_nettype none
module esa_admission
   import esa_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                arst_n,
   input  wire logic                reqValid,
   input  wire logic [7:0]          opcByte0,
   input  wire logic [7:0]          opcByte1,
   input  wire logic [7:0]          opcByte2,
   input  wire esa_prefix_t         prefix,
   input  wire logic [ACC_W-1:0]    accumulator,
   input  wire esa_cpu_t            cpu,
   input  wire logic [BITMAP_W-1:0] exitBitmap,
   input  wire logic [CTRL_W-1:0]   ctrlStructId,
   input  wire logic                leafDone,
   input  wire logic [CTRL_W-1:0]   leafDoneId,
   output logic                     resValid,
   output esa_result_t              result,
   output logic                     trackBusy
);

   logic              opcodeHit;
   logic [LEAF_W-1:0] leaf;
   logic              mode64;
   logic              udMode;
   logic              udCpl;
   logic              udFeature;
   logic              udPrefix;
   logic              exitTaken;
   logic              gpFeat;
   logic              gpLeaf;
   logic              gpPaging;
   logic              gpSegment;
   logic              trackReq;
   logic              granted;
   esa_outcome_t      next_outcome;
   esa_result_t       next_result;

   assign opcodeHit = opcByte0 == OPC_BYTE0 && opcByte1 == OPC_BYTE1
                      && opcByte2 == OPC_BYTE2;

   // Upper accumulator half never reaches the decode, in either width
   assign leaf   = accumulator[LEAF_W-1:0];
   assign mode64 = cpu.longActive && cpu.csLong;

   // Compatibility mode is just mode64 low, so it meets the same checks
   assign udMode    = !cpu.protEnable || cpu.v86 || cpu.smm;
   assign udCpl     = cpu.cpl != TOP_CPL;
   assign udFeature = !cpu.gen1Feature;
   // Segment override, address size and extension prefixes are not looked at
   assign udPrefix  = prefix.busLock || prefix.opSize || prefix.repeatPfx
                      || prefix.vecExt;

   assign exitTaken = cpu.guestMode && cpu.exitCtl
                      && exitBitmap[esa_bm_index(leaf)];

   assign gpFeat    = !cpu.featLock || !cpu.enclaveEnable;
   assign gpLeaf    = !esa_leaf_valid(leaf);
   assign gpPaging  = !cpu.pagingEnable;
   assign gpSegment = !mode64 && cpu.dsExpandDown;

   // Priority chain; the lock is only asked for once every fault has passed
   always_comb
   begin
      next_outcome = ESA_ADMIT;
      if (!opcodeHit)
         next_outcome = ESA_NONE;
      else if (cpu.txnActive)
         next_outcome = ESA_TXN_ABORT;
      else if (udMode || udCpl || udFeature || udPrefix)
         next_outcome = ESA_UD;
      else if (exitTaken)
         next_outcome = ESA_VMEXIT;
      else if (gpFeat || gpLeaf || gpPaging || gpSegment)
         next_outcome = ESA_GP;
   end

   assign trackReq = reqValid && next_outcome == ESA_ADMIT && esa_is_track(leaf);

   esa_track_lock u_lock
   (
      .clk       (clk),
      .arst_n    (arst_n),
      .acquire   (trackReq),
      .acquireId (ctrlStructId),
      .retire    (leafDone),
      .releaseId (leafDoneId),
      .granted   (granted),
      .busyAny   (trackBusy)
   );

   always_comb
   begin
      next_result              = '0;
      next_result.outcome      = next_outcome;
      next_result.leaf         = leaf;
      next_result.wide64       = mode64;
      next_result.errCode      = FAULT_ERRCODE;
      if (trackReq && !granted)
      begin
         next_result.outcome      = ESA_CONFLICT;
         next_result.pageConflict = 1'b1;
         // Only a guest has a hypervisor to hear the qualifier
         next_result.trackQual    = cpu.guestMode;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         resValid <= 1'b0;
      else
         resValid <= reqValid;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         result <= '0;
      else if (reqValid)
         result <= next_result;
   end

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   logic hitReq;
   assign hitReq = reqValid && opcodeHit;

   // Request that has cleared the invalid-opcode stage, then the exit stage
   logic passUd;
   logic passExit;
   assign passUd   = hitReq && !cpu.txnActive && !udMode && !udCpl
                     && !udFeature && !udPrefix;
   assign passExit = passUd && !exitTaken;

   sequence s_track_grant;
      trackReq && granted && !leafDone;
   endsequence

   sequence s_track_again;
      trackReq && ctrlStructId == $past(ctrlStructId)
      && !(leafDone && leafDoneId == ctrlStructId);
   endsequence

   chk_opcode_match:
      assert property (reqValid |=> resValid
                       && ((result.outcome == ESA_NONE) == !$past(opcodeHit)))
      else $error("opcode recognition mismatch");

   chk_leaf_low:
      assert property (reqValid |=> result.leaf == $past(accumulator[LEAF_W-1:0]))
      else $error("leaf not taken from low accumulator half");

   chk_txn_first:
      assert property (hitReq && cpu.txnActive |=> result.outcome == ESA_TXN_ABORT)
      else $error("active transaction did not abort first");

   chk_ud_mode:
      assert property (hitReq && !cpu.txnActive && (!cpu.protEnable || cpu.v86 || cpu.smm)
                       |=> result.outcome == ESA_UD)
      else $error("mode fault not raised as invalid opcode");

   chk_ud_cpl:
      assert property (hitReq && !cpu.txnActive && cpu.cpl != 2'h0
                       |=> result.outcome == ESA_UD)
      else $error("privilege fault missing");

   chk_ud_feature:
      assert property (hitReq && !cpu.txnActive && !cpu.gen1Feature
                       |=> result.outcome == ESA_UD)
      else $error("feature bit fault missing");

   chk_ud_prefix:
      assert property (hitReq && !cpu.txnActive
                       && (prefix.busLock || prefix.opSize || prefix.repeatPfx || prefix.vecExt)
                       |=> result.outcome == ESA_UD)
      else $error("prefix fault missing");

   chk_exit_catchall:
      assert property (hitReq && !cpu.txnActive && !udMode && !udCpl && !udFeature
                       && !udPrefix && cpu.guestMode && cpu.exitCtl && leaf > 32'd62
                       |=> (result.outcome == ESA_VMEXIT) == $past(exitBitmap[63]))
      else $error("high leaf did not use catch-all bitmap bit");

   chk_exit_order:
      assert property (resValid && result.outcome == ESA_VMEXIT
                       |-> $past(!udMode && !udCpl && !udFeature && !udPrefix && cpu.guestMode))
      else $error("exit taken ahead of an invalid-opcode cause");

   chk_gp_code:
      assert property (resValid && result.outcome == ESA_GP |-> result.errCode == 32'h0)
      else $error("general protection error code not zero");

   chk_gp_paging:
      assert property (hitReq && !cpu.txnActive && !udMode && !udCpl && !udFeature
                       && !udPrefix && !exitTaken && !cpu.pagingEnable
                       |=> result.outcome == ESA_GP)
      else $error("paging off did not fault");

   chk_ds_expand:
      assert property (resValid && result.outcome == ESA_ADMIT
                       |-> !$past(cpu.dsExpandDown) || $past(mode64))
      else $error("expand-down segment admitted outside 64-bit mode");

   chk_width_mode:
      assert property (reqValid |=> result.wide64 == $past(cpu.longActive && cpu.csLong))
      else $error("width does not follow 64-bit mode");

   chk_track_excl:
      assert property (s_track_grant ##1 s_track_again
                       |=> result.outcome == ESA_CONFLICT && result.pageConflict)
      else $error("second tracking leaf not refused");

   chk_exit_direct:
      assert property (passUd && cpu.guestMode && cpu.exitCtl && leaf <= 32'd62
                       |=> (result.outcome == ESA_VMEXIT) == $past(exitBitmap[leaf[5:0]]))
      else $error("direct leaf did not follow its bitmap bit");

   chk_exit_gated:
      assert property (passUd && !(cpu.guestMode && cpu.exitCtl)
                       |=> result.outcome != ESA_VMEXIT)
      else $error("exit taken without guest exit control");

   chk_gp_feature:
      assert property (passExit && (!cpu.featLock || !cpu.enclaveEnable)
                       |=> result.outcome == ESA_GP)
      else $error("feature control fault missing");

   chk_gp_leaf:
      assert property (passExit && accumulator[LEAF_W-1:0] >= LEAF_COUNT
                       |=> result.outcome == ESA_GP)
      else $error("undefined leaf not faulted");

   chk_gp_segment:
      assert property (passExit && !(cpu.longActive && cpu.csLong) && cpu.dsExpandDown
                       |=> result.outcome == ESA_GP)
      else $error("expand-down segment not faulted");

   // Admission must imply the feature, paging and leaf conditions held at the request
   chk_admit_clean:
      assert property (resValid && result.outcome == ESA_ADMIT
                       |-> $past(cpu.featLock && cpu.enclaveEnable && cpu.pagingEnable
                                 && leaf < LEAF_COUNT))
      else $error("admitted despite a protection cause");

   // Segment, address-size and extension prefixes are not in the cause list
   chk_ud_cause:
      assert property (resValid && result.outcome == ESA_UD
                       |-> $past(!cpu.protEnable || cpu.v86 || cpu.smm || cpu.cpl != TOP_CPL
                                 || !cpu.gen1Feature || prefix.busLock || prefix.opSize
                                 || prefix.repeatPfx || prefix.vecExt))
      else $error("invalid opcode raised without a cause");

   chk_result_hold:
      assert property (!reqValid |=> $stable(result) && !resValid)
      else $error("result changed without a request");

   chk_conflict_flags:
      assert property (resValid && result.outcome == ESA_CONFLICT
                       |-> result.pageConflict && result.trackQual == $past(cpu.guestMode))
      else $error("conflict without page conflict report");

   chk_conflict_track:
      assert property (resValid && result.pageConflict
                       |-> result.outcome == ESA_CONFLICT && esa_is_track(result.leaf))
      else $error("page conflict outside a tracking leaf");

   chk_busy_set:
      assert property (trackReq && granted |=> trackBusy)
      else $error("granted structure not marked busy");

   chk_compat_width:
      assert property (reqValid && cpu.longActive && !cpu.csLong |=> !result.wide64)
      else $error("compatibility mode given 64-bit width");

endmodule
`default_nettype wire

/* test/esa_leaf_flow_model.sv */
/*
   Leaf-flow model that stands behind the admission block: it finishes each
   admitted tracking leaf after holdCycles and releases its busy mark.
   Assumes the block's clock; it drives its outputs at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module esa_leaf_flow_model
   import esa_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              reqValid,
   input  wire logic [CTRL_W-1:0] ctrlStructId,
   input  wire logic              resValid,
   input  wire esa_result_t       result,
   input  wire logic [7:0]        holdCycles,
   output logic                   leafDone,
   output logic [CTRL_W-1:0]      leafDoneId
);
   int unsigned       cyc = 0;
   logic [CTRL_W-1:0] takenId = '0;
   logic [CTRL_W-1:0] ids[$];
   int unsigned       dues[$];
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (reqValid)
         takenId <= ctrlStructId;
   end
   always @(negedge clk)
   begin
      if (resValid && result.outcome == ESA_ADMIT &&
          (result.leaf == TRACK_LEAF || result.leaf == TRACK_CHK_LEAF))
      begin
         ids.push_back(takenId);
         dues.push_back(cyc + holdCycles);
      end
      // One release a cycle; idle id keeps changing so a stale id never matches
      if (ids.size() > 0 && cyc >= dues[0])
      begin
         leafDone <= 1'b1;
         leafDoneId <= ids.pop_front();
         void'(dues.pop_front());
      end
      else
      begin
         leafDone <= 1'b0;
         leafDoneId <= CTRL_W'(cyc);
      end
   end
endmodule
`default_nettype wire

/* test/esa_admission_bench.sv */
/*
   Self-checking bench for the admission block: random back-to-back requests
   against a reference of the check order, then tracking-leaf exclusion.
   Assumes the leaf-flow model releases admitted tracking leaves.
*/
`timescale 1ns/1ps
`default_nettype none
module esa_admission_bench
   import esa_pkg::*;
;
   typedef struct packed { esa_result_t r; logic [31:0] cy; } esa_note_t;
   logic clk = 0, arst_n = 0, reqValid = 0, resValid, trackBusy, leafDone;
   logic [7:0] opcByte0 = OPC_BYTE0, opcByte1 = OPC_BYTE1, opcByte2 = OPC_BYTE2;
   logic [7:0] holdCycles = 8'h04;
   esa_prefix_t prefix = '0;
   esa_cpu_t cpu = '0;
   esa_result_t result;
   logic [ACC_W-1:0] accumulator = '0;
   logic [BITMAP_W-1:0] exitBitmap = '0;
   logic [CTRL_W-1:0] ctrlStructId = '0, leafDoneId;
   int miscompares = 0, num_checks = 0, seed = 45, cyc = 0;
   esa_note_t notes[$];
   esa_admission dut_u (.clk, .arst_n, .reqValid, .opcByte0, .opcByte1, .opcByte2,
      .prefix, .accumulator, .cpu, .exitBitmap, .ctrlStructId, .leafDone,
      .leafDoneId, .resValid, .result, .trackBusy);
   esa_leaf_flow_model flow_u (.clk, .reqValid, .ctrlStructId, .resValid, .result,
      .holdCycles, .leafDone, .leafDoneId);
   always #20 clk = ~clk;
   task automatic check(string nm, logic [69:0] seen, logic [69:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   function automatic logic f(int n);
      f = ($random(seed) % n) == 0;
   endfunction
   // Reference of the check order, written from the admission rules
   function automatic esa_result_t model();
      esa_result_t r;
      logic m64;
      logic [31:0] lf;
      r = '0;
      lf = accumulator[31:0];
      m64 = cpu.longActive & cpu.csLong;
      r.leaf = lf;
      r.wide64 = m64;
      if ({opcByte0, opcByte1, opcByte2} != 24'h0F01CF) r.outcome = ESA_NONE;
      else if (cpu.txnActive) r.outcome = ESA_TXN_ABORT;
      else if (!cpu.protEnable || cpu.v86 || cpu.smm || cpu.cpl != 2'h0 || !cpu.gen1Feature
         || prefix.busLock || prefix.opSize || prefix.repeatPfx || prefix.vecExt)
         r.outcome = ESA_UD;
      else if (cpu.guestMode && cpu.exitCtl && exitBitmap[(lf > 62) ? 63 : lf[5:0]])
         r.outcome = ESA_VMEXIT;
      else if (!cpu.featLock || !cpu.enclaveEnable || lf >= 32'h18 || !cpu.pagingEnable
         || (!m64 && cpu.dsExpandDown))
         r.outcome = ESA_GP;
      else r.outcome = ESA_ADMIT;
      model = r;
   endfunction
   task automatic send(logic cf);
      esa_note_t n;
      n.r = model();
      n.cy = cyc + 1;
      if (cf)
      begin
         n.r.outcome = ESA_CONFLICT;
         n.r.pageConflict = 1'b1;
         n.r.trackQual = cpu.guestMode;
      end
      notes.push_back(n);
      reqValid = 1'b1;
   endtask
   task automatic trk(logic [31:0] lf, logic [15:0] id, logic cf);
      @(negedge clk);
      accumulator = {accumulator[63:32], lf};
      ctrlStructId = id;
      send(cf);
   endtask
   task automatic idle(int n);
      repeat (n) @(negedge clk) reqValid = 1'b0;
   endtask
   always @(negedge clk)
   begin
      if (arst_n && resValid !== 1'b0)
      begin
         if (notes.size() == 0)
            check("spurious resValid", 1, 0);
         else
         begin
            check("latency", cyc, notes[0].cy);
            if (notes[0].r.outcome == ESA_NONE)
               check("outcome", result.outcome, ESA_NONE);
            else
               check("result", result, notes[0].r);
            void'(notes.pop_front());
         end
      end
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc >= 3000)
      begin
         miscompares++;
         final_report();
      end
   end
   initial
   begin
      repeat (20) @(negedge clk);
      arst_n = 1'b1;
      repeat (400)
      begin
         @(negedge clk);
         cpu = {!f(8), f(8), f(8), f(8) ? 2'(1 + $unsigned($random(seed)) % 3) : 2'h0,
            !f(8), !f(8), !f(8), !f(8), f(2), f(2), f(4), f(2), f(2), f(16)};
         prefix = {f(16), f(16), f(16), f(16), f(2), f(2), f(2)};
         opcByte2 = f(16) ? (f(2) ? 8'hD7 : 8'hC0) : OPC_BYTE2;
         accumulator = {$random(seed), $random(seed)};
         if (!f(4))
            accumulator[31:0] = f(3) ? (f(2) ? 32'h3E : 32'h3F) : accumulator[31:0] & 32'h3F;
         if (accumulator[31:0] == TRACK_LEAF || accumulator[31:0] == TRACK_CHK_LEAF)
            accumulator[31:0] = accumulator[31:0] + 32'h1;
         exitBitmap = {$random(seed), $random(seed)};
         ctrlStructId = CTRL_W'($random(seed));
         send(1'b0);
      end
      idle(3);
      // Protected, ring 0, features on, 64-bit, guest with exit control, no exits
      cpu = 15'b100001111110110;
      prefix = 7'b0000100;
      opcByte2 = OPC_BYTE2;
      exitBitmap = '0;
      trk(TRACK_LEAF, 16'h5, 1'b0);
      trk(TRACK_CHK_LEAF, 16'h5, 1'b1);
      idle(1);
      check("busy", trackBusy, 1'b1);
      idle(10);
      check("released", trackBusy, 1'b0);
      holdCycles = 8'h3C;
      cpu.guestMode = 1'b0;
      for (int i = 0; i < SLOTS; i++)
         trk(i[0] ? TRACK_CHK_LEAF : TRACK_LEAF, 16'(i + 1), 1'b0);
      trk(TRACK_LEAF, 16'h9, 1'b1);
      trk(32'h0, 16'h9, 1'b0);
      idle(80);
      check("all released", trackBusy, 1'b0);
      trk(TRACK_CHK_LEAF, 16'h9, 1'b0);
      idle(70);
      check("notes left", notes.size(), 0);
      final_report();
   end
endmodule
`default_nettype wire
